//--- logic/aid_pkg.sv
// package: opcodes, flag layout and timing constants for the alu datapath
package aid_pkg;

    // ==========================================
    // timing and reset values
    // ==========================================
    localparam int CLK_PER_ICYCLE = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [7:0] ACC_RESET = 8'h00;

    // ==========================================
    // operations
    // ==========================================
    typedef enum logic [5:0] {
        OP_NOP,
        OP_MOVE_BYTE_TO_ACC,
        OP_MOVE_BYTE_TO_MEM,
        OP_MOVE_IMM_TO_ACC,
        OP_ADD,
        OP_ADD_WITH_CARRY,
        OP_SUB,
        OP_SUBTRACT_WITH_BORROW,
        OP_DECIMAL_ADJUST,
        OP_AND,
        OP_OR,
        OP_XOR,
        OP_INVERT,
        OP_INCREMENT,
        OP_DECREMENT,
        OP_ROTATE_RIGHT,
        OP_ROTATE_LEFT,
        OP_ROTATE_RIGHT_THROUGH_CARRY,
        OP_ROTATE_LEFT_THROUGH_CARRY,
        OP_BIT_SET,
        OP_BIT_CLEAR,
        OP_SKIP_IF_ZERO,
        OP_SKIP_IF_BIT_ZERO,
        OP_SKIP_IF_BIT_SET,
        OP_UNCONDITIONAL_JUMP,
        OP_CALL,
        OP_SUBROUTINE_RETURN
    } aid_op_t;

    // ==========================================
    // carriers
    // ==========================================
    typedef struct packed {
        aid_op_t op;
        logic use_imm;    // operand b is the literal, not memory
        logic to_mem;     // result goes to memory, else accumulator
        logic [2:0] bit_sel;
        logic [7:0] imm;
        logic pcl_dest;   // destination is the program counter low byte
    } aid_instr_t;

    typedef struct packed {
        logic overflow_flag;
        logic half_carry_flag;
        logic carry;
        logic zero;
    } aid_flags_t;

endpackage

//--- logic/aid_datapath.sv
// accumulator alu datapath with four-clock instruction cycle
// Function
// - moves: memory to accumulator, accumulator to memory, literal in.
// - memory plus accumulator into accumulator, one cycle, four flags.
// - add with carry sums accumulator, memory, carry; four flags.
// - memory-destination add, with or without carry, writes memory.
// - literal add into accumulator in one cycle, four flags.
// - literal and memory subtract into accumulator, one cycle, four flags.
// - memory-destination subtract writes difference to memory.
// - subtract with borrow uses carry, to accumulator or memory.
// - decimal adjust of accumulator written to memory, carry only.
// - and/or/xor with memory into accumulator, zero flag only.
// - memory-destination logic ops write memory, zero flag only.
// - literal logic ops into accumulator, zero flag only.
// - complement of memory to memory or accumulator, zero only.
// - increment of memory to memory or accumulator, zero only.
// - decrement of memory to memory or accumulator, zero only.
// - plain rotates wrap end bit, no flags changed.
// - rotate right through carry, carry only.
// - rotate left through carry, carry only.
// - carry is add carry-out above 255; for subtract it is set on no borrow, cleared below 0.
// - bit set and clear change only bit 0 to 7 selected.
// - skips test byte or bit and skip next instruction if true.
// - call saves return point, return resumes after it; jump saves none.
// - instruction cycle is four clocks.
// - program counter low writes and taken skips take two cycles.
module aid_datapath
    import aid_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // instruction from decode, sampled at the start of a cycle
    input wire logic instr_valid_i,
    input aid_instr_t instr_i,
    output logic instr_ready_o,
    // data memory
    input wire logic [7:0] mem_rdata_i,
    output logic [7:0] mem_wdata_o,
    output logic mem_we_o,
    // results to core sequencing
    output logic [7:0] acc_o,
    output aid_flags_t flags_o,
    output logic skip_o,
    output logic push_return_o,
    output logic pop_return_o,
    output logic busy_o
);

    // ==========================================
    // instruction cycle sequencing
    // ==========================================
    logic [1:0] phase_reg, phase_next;
    logic second_reg, second_next;
    logic active_reg, active_next;
    aid_instr_t ins_reg, ins_next;
    logic long_op;

    // a new instruction is accepted only at phase 0 of an idle slot
    assign instr_ready_o = !active_reg;
    assign busy_o = active_reg;

    always_comb begin
        phase_next = phase_reg;
        second_next = second_reg;
        active_next = active_reg;
        ins_next = ins_reg;
        if (!active_reg) begin
            if (instr_valid_i) begin
                active_next = 1'b1;
                ins_next = instr_i;
                phase_next = 2'h0;
                second_next = 1'b0;
            end
        end else begin
            phase_next = phase_reg + 2'h1;
            if (phase_reg == PHASE_LAST) begin
                if (long_op && !second_reg) begin
                    second_next = 1'b1;
                end else begin
                    active_next = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            phase_reg <= 2'h0;
            second_reg <= 1'b0;
            active_reg <= 1'b0;
            ins_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            second_reg <= second_next;
            active_reg <= active_next;
            ins_reg <= ins_next;
        end
    end

    // ==========================================
    // arithmetic and logic
    // ==========================================
    logic [7:0] acc_reg, acc_next;
    aid_flags_t flg_reg, flg_next;
    logic [7:0] opb, res;
    logic [8:0] sum;
    logic [4:0] low;
    logic wr_acc, wr_mem, upd_arith, upd_zero, upd_carry, new_carry;
    logic skip_hit, is_sub;
    logic [7:0] adj;

    assign opb = ins_reg.use_imm ? ins_reg.imm : mem_rdata_i;

    always_comb begin
        res = 8'h00;
        sum = 9'h000;
        low = 5'h00;
        adj = acc_reg;
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        upd_arith = 1'b0;
        upd_zero = 1'b0;
        upd_carry = 1'b0;
        new_carry = flg_reg.carry;
        skip_hit = 1'b0;
        is_sub = 1'b0;
        case (ins_reg.op)
            OP_MOVE_BYTE_TO_ACC, OP_MOVE_IMM_TO_ACC: begin
                res = opb;
                wr_acc = 1'b1;
            end
            OP_MOVE_BYTE_TO_MEM: begin
                res = acc_reg;
                wr_mem = 1'b1;
            end
            OP_ADD, OP_ADD_WITH_CARRY: begin
                sum = {1'b0, acc_reg} + {1'b0, opb} +
                      {8'h00, ins_reg.op == OP_ADD_WITH_CARRY
                              && flg_reg.carry};
                low = {1'b0, acc_reg[3:0]} + {1'b0, opb[3:0]} +
                      {4'h0, ins_reg.op == OP_ADD_WITH_CARRY
                             && flg_reg.carry};
                res = sum[7:0];
                new_carry = sum[8];
                upd_arith = 1'b1;
                wr_mem = ins_reg.to_mem;
                wr_acc = !ins_reg.to_mem;
            end
            OP_SUB, OP_SUBTRACT_WITH_BORROW: begin
                // carry set means no borrow; with-borrow uses carry as
                // the inverse of borrow in
                is_sub = 1'b1;
                sum = {1'b0, acc_reg} + {1'b0, ~opb} +
                      {8'h00, ins_reg.op == OP_SUB || flg_reg.carry};
                low = {1'b0, acc_reg[3:0]} + {1'b0, ~opb[3:0]} +
                      {4'h0, ins_reg.op == OP_SUB || flg_reg.carry};
                res = sum[7:0];
                new_carry = sum[8];
                upd_arith = 1'b1;
                wr_mem = ins_reg.to_mem;
                wr_acc = !ins_reg.to_mem;
            end
            OP_DECIMAL_ADJUST: begin
                if (acc_reg[3:0] > 4'h9 || flg_reg.half_carry_flag) begin
                    adj = acc_reg + 8'h06;
                end
                sum = {1'b0, adj};
                if (adj[7:4] > 4'h9 || flg_reg.carry ||
                    (acc_reg[3:0] > 4'h9 && acc_reg[7:4] == 4'h9)) begin
                    sum = {1'b0, adj} + 9'h060;
                end
                res = sum[7:0];
                new_carry = sum[8] || flg_reg.carry;
                upd_carry = 1'b1;
                wr_mem = 1'b1;
            end
            OP_AND, OP_OR, OP_XOR: begin
                res = (ins_reg.op == OP_AND) ? (acc_reg & opb) :
                      (ins_reg.op == OP_OR) ? (acc_reg | opb) :
                      (acc_reg ^ opb);
                upd_zero = 1'b1;
                wr_mem = ins_reg.to_mem;
                wr_acc = !ins_reg.to_mem;
            end
            OP_INVERT, OP_INCREMENT, OP_DECREMENT: begin
                res = (ins_reg.op == OP_INVERT) ? ~mem_rdata_i :
                      (ins_reg.op == OP_INCREMENT) ? mem_rdata_i + 8'h01 :
                      mem_rdata_i - 8'h01;
                upd_zero = 1'b1;
                wr_mem = ins_reg.to_mem;
                wr_acc = !ins_reg.to_mem;
            end
            OP_ROTATE_RIGHT, OP_ROTATE_LEFT: begin
                res = (ins_reg.op == OP_ROTATE_RIGHT) ?
                      {mem_rdata_i[0], mem_rdata_i[7:1]} :
                      {mem_rdata_i[6:0], mem_rdata_i[7]};
                wr_mem = ins_reg.to_mem;
                wr_acc = !ins_reg.to_mem;
            end
            OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                res = {flg_reg.carry, mem_rdata_i[7:1]};
                new_carry = mem_rdata_i[0];
                upd_carry = 1'b1;
                wr_mem = ins_reg.to_mem;
                wr_acc = !ins_reg.to_mem;
            end
            OP_ROTATE_LEFT_THROUGH_CARRY: begin
                res = {mem_rdata_i[6:0], flg_reg.carry};
                new_carry = mem_rdata_i[7];
                upd_carry = 1'b1;
                wr_mem = ins_reg.to_mem;
                wr_acc = !ins_reg.to_mem;
            end
            OP_BIT_SET, OP_BIT_CLEAR: begin
                // read-modify-write keeps the other seven bits
                res = mem_rdata_i;
                res[ins_reg.bit_sel] = (ins_reg.op == OP_BIT_SET);
                wr_mem = 1'b1;
            end
            OP_SKIP_IF_ZERO: begin
                skip_hit = (mem_rdata_i == 8'h00);
            end
            OP_SKIP_IF_BIT_ZERO: begin
                skip_hit = !mem_rdata_i[ins_reg.bit_sel];
            end
            OP_SKIP_IF_BIT_SET: begin
                skip_hit = mem_rdata_i[ins_reg.bit_sel];
            end
            default: begin
                res = 8'h00;
            end
        endcase
    end

    // two-cycle when the result lands in program counter low, on a taken skip, or for jump, call and return
    assign long_op = skip_hit || (wr_mem && ins_reg.pcl_dest) ||
                     ins_reg.op == OP_UNCONDITIONAL_JUMP ||
                     ins_reg.op == OP_CALL ||
                     ins_reg.op == OP_SUBROUTINE_RETURN;

    // ==========================================
    // state update at the last clock of the first instruction cycle
    // ==========================================
    logic commit;
    logic [7:0] wdata_reg, wdata_next;
    logic we_reg, we_next, skip_reg, skip_next;
    logic push_reg, push_next, pop_reg, pop_next;

    assign commit = active_reg && !second_reg && phase_reg == PHASE_LAST;

    always_comb begin
        acc_next = acc_reg;
        flg_next = flg_reg;
        wdata_next = wdata_reg;
        we_next = 1'b0;
        skip_next = 1'b0;
        push_next = 1'b0;
        pop_next = 1'b0;
        if (commit) begin
            if (wr_acc) begin
                acc_next = res;
            end
            if (wr_mem) begin
                wdata_next = res;
                we_next = 1'b1;
            end
            if (upd_arith) begin
                flg_next.zero = (res == 8'h00);
                flg_next.carry = new_carry;
                flg_next.half_carry_flag = low[4] ^ is_sub ^ is_sub;
                flg_next.overflow_flag =
                    (acc_reg[7] == (opb[7] ^ is_sub)) &&
                    (res[7] != acc_reg[7]);
            end
            if (upd_zero) begin
                flg_next.zero = (res == 8'h00);
            end
            if (upd_carry) begin
                flg_next.carry = new_carry;
            end
            skip_next = skip_hit;
            push_next = (ins_reg.op == OP_CALL);
            pop_next = (ins_reg.op == OP_SUBROUTINE_RETURN);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            acc_reg <= ACC_RESET;
            flg_reg <= FLAGS_RESET;
            wdata_reg <= 8'h00;
            we_reg <= 1'b0;
            skip_reg <= 1'b0;
            push_reg <= 1'b0;
            pop_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            flg_reg <= flg_next;
            wdata_reg <= wdata_next;
            we_reg <= we_next;
            skip_reg <= skip_next;
            push_reg <= push_next;
            pop_reg <= pop_next;
        end
    end

    assign acc_o = acc_reg;
    assign flags_o = flg_reg;
    assign mem_wdata_o = wdata_reg;
    assign mem_we_o = we_reg;
    assign skip_o = skip_reg;
    assign push_return_o = push_reg;
    assign pop_return_o = pop_reg;

endmodule

//--- test/aid_datapath_sva.sv
// checker: timing, pulse and flag assertions for the alu datapath
module aid_datapath_sva
    import aid_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // instruction
    input wire logic instr_valid_i,
    input aid_instr_t instr_i,
    input wire logic instr_ready_o,
    // memory
    input wire logic [7:0] mem_rdata_i,
    input wire logic [7:0] mem_wdata_o,
    input wire logic mem_we_o,
    // results
    input wire logic [7:0] acc_o,
    input aid_flags_t flags_o,
    input wire logic skip_o,
    input wire logic push_return_o,
    input wire logic pop_return_o,
    input wire logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ==========================================
    // sequences
    // ==========================================
    sequence s_take;
        instr_valid_i && instr_ready_o;
    endsequence
    sequence s_short;
        busy_o [*4] ##1 !busy_o;
    endsequence
    sequence s_long;
        busy_o [*8] ##1 !busy_o;
    endsequence
    // ==========================================
    // properties
    // ==========================================
    property p_ready;
        instr_ready_o == !busy_o;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready not idle");
    property p_take_busy;
        s_take |=> busy_o && !instr_ready_o;
    endproperty
    a_take_busy: assert property (p_take_busy)
        else $error("take not refused");
    property p_add_len;
        s_take ##0 (instr_i.op == OP_ADD && !instr_i.pcl_dest) |=> s_short;
    endproperty
    a_add_len: assert property (p_add_len)
        else $error("add length");
    property p_jump_len;
        s_take ##0 (instr_i.op == OP_UNCONDITIONAL_JUMP) |=> s_long;
    endproperty
    a_jump_len: assert property (p_jump_len)
        else $error("jump length");
    property p_call_push;
        s_take ##0 (instr_i.op == OP_CALL) |-> ##[1:8] push_return_o;
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("no push");
    property p_jump_quiet;
        s_take ##0 (instr_i.op == OP_UNCONDITIONAL_JUMP)
            |=> (!push_return_o && !pop_return_o) [*8];
    endproperty
    a_jump_quiet: assert property (p_jump_quiet)
        else $error("jump push");
    property p_ret_pop;
        s_take ##0 (instr_i.op == OP_SUBROUTINE_RETURN)
            |-> ##[1:8] pop_return_o;
    endproperty
    a_ret_pop: assert property (p_ret_pop)
        else $error("no pop");
    property p_rot_flags;
        s_take ##0 (instr_i.op == OP_ROTATE_RIGHT) |=> $stable(flags_o) [*6];
    endproperty
    a_rot_flags: assert property (p_rot_flags)
        else $error("rotate flags");
    property p_and_flags;
        s_take ##0 (instr_i.op == OP_AND) |=> $stable(flags_o[3:1]) [*6];
    endproperty
    a_and_flags: assert property (p_and_flags)
        else $error("and flags");
    property p_idle_hold;
        !busy_o && !$past(busy_o) |-> $stable(acc_o) && $stable(flags_o);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("idle change");
    property p_we_pulse;
        mem_we_o |=> !mem_we_o;
    endproperty
    a_we_pulse: assert property (p_we_pulse)
        else $error("write width");
    property p_skip_pulse;
        skip_o |=> !skip_o;
    endproperty
    a_skip_pulse: assert property (p_skip_pulse)
        else $error("skip width");
endmodule
bind aid_datapath aid_datapath_sva u_sva (.clk_i(clk_i), .reset_i(reset_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_ready_o(instr_ready_o), .mem_rdata_i(mem_rdata_i),
    .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .acc_o(acc_o),
    .flags_o(flags_o), .skip_o(skip_o), .push_return_o(push_return_o),
    .pop_return_o(pop_return_o), .busy_o(busy_o));

//--- test/aid_mem_model.sv
// partner model: one data memory byte behind the operand address
module aid_mem_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic load_i,
    input wire logic [7:0] load_data_i,
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] byte_reg;
    logic [7:0] byte_next;
    // operand only moves on a load or a write strobe, so it holds until the op commits
    always_comb begin
        byte_next = byte_reg;
        if (load_i) begin
            byte_next = load_data_i;
        end else if (we_i) begin
            byte_next = wdata_i;
        end
    end
    always_ff @(posedge clk_i) begin
        byte_reg <= reset_i ? 8'h00 : byte_next;
    end
    assign rdata_o = byte_reg;
endmodule

//--- test/tb.sv
// testbench: directed scenarios for the alu datapath
module tb;
    import aid_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic instr_valid_i = 1'b0;
    aid_instr_t instr_i = '0;
    logic load = 1'b0;
    logic [7:0] load_data = 8'h00;
    logic program_counter_low = 1'b0;
    wire logic [7:0] mem_rdata, mem_wdata, acc_o;
    wire logic mem_we, ready, skip_o, push_o, pop_o, busy_o;
    aid_flags_t flags_o;
    logic [7:0] ea = 8'h00;
    logic [3:0] ef = 4'h0;
    logic [7:0] em = 8'h00;
    int error_cnt = 0;
    int comparisons = 0;
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    aid_datapath DUT (.clk_i(clk_i), .reset_i(reset_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .instr_ready_o(ready), .mem_rdata_i(mem_rdata),
        .mem_wdata_o(mem_wdata), .mem_we_o(mem_we), .acc_o(acc_o),
        .flags_o(flags_o), .skip_o(skip_o), .push_return_o(push_o),
        .pop_return_o(pop_o), .busy_o(busy_o));
    aid_mem_model u_mem (.clk_i(clk_i), .reset_i(reset_i), .load_i(load),
        .load_data_i(load_data), .we_i(mem_we), .wdata_i(mem_wdata),
        .rdata_o(mem_rdata));
    // ==========================================
    // shared tasks
    // ==========================================
    task automatic final_report();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, g, e);
        end
    endtask
    task automatic ld(input logic [7:0] x);
        @(posedge clk_i);
        load <= 1'b1;
        load_data <= x;
        em = x;
        @(posedge clk_i);
        load <= 1'b0;
    endtask
    // md: {use_imm, to_mem, bit_sel}; ev: {skip, push, pop}
    task automatic ex(input aid_op_t op, input logic [4:0] md,
        input logic [7:0] x, input logic [7:0] a, input logic [3:0] f,
        input logic [7:0] m, input int n, input logic [2:0] ev);
        int k;
        logic [2:0] seen;
        k = 0;
        seen = 3'h0;
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= '{op, md[4], md[3], md[2:0], x, program_counter_low};
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        do begin
            @(posedge clk_i);
            #1;
            k++;
            seen |= {skip_o, push_o, pop_o};
        end while (busy_o !== 1'b0 && k < 20);
        if (k >= 20) begin
            error_cnt++;
            final_report();
        end
        // memory write lands one edge after the strobe
        @(posedge clk_i);
        #1;
        cmp(8'(k), 8'(n));
        cmp({5'h0, seen}, {5'h0, ev});
        cmp(acc_o, a);
        cmp({4'h0, flags_o}, {4'h0, f});
        cmp(mem_rdata, m);
        ea = a;
        ef = f;
        em = m;
    endtask
    task automatic ax(input aid_op_t op, input logic [4:0] md,
        input logic [7:0] x, input logic [7:0] a, input logic [3:0] f,
        input logic [7:0] m);
        ex(op, md, x, a, f, m, 4, 3'h0);
    endtask
    task automatic fl(input aid_op_t op, input logic [2:0] b, input int n,
        input logic [2:0] ev);
        ex(op, {2'b00, b}, 8'h00, ea, ef, em, n, ev);
    endtask
    // ==========================================
    // scenarios
    // ==========================================
    task automatic t_move();
        ld(8'h5a);
        ax(OP_MOVE_BYTE_TO_ACC, 5'h00, 8'h00, 8'h5a, 4'h0, 8'h5a);
        ax(OP_MOVE_IMM_TO_ACC, 5'h10, 8'h3c, 8'h3c, 4'h0, 8'h5a);
        ax(OP_MOVE_BYTE_TO_MEM, 5'h08, 8'h00, 8'h3c, 4'h0, 8'h3c);
    endtask
    task automatic t_add();
        ax(OP_MOVE_IMM_TO_ACC, 5'h10, 8'h7f, 8'h7f, 4'h0, 8'h3c);
        ax(OP_ADD, 5'h10, 8'h01, 8'h80, 4'hc, 8'h3c);
        ld(8'h80);
        ax(OP_ADD, 5'h00, 8'h00, 8'h00, 4'hb, 8'h80);
        ld(8'h0f);
        ax(OP_ADD_WITH_CARRY, 5'h00, 8'h00, 8'h10, 4'h4, 8'h0f);
        ld(8'hf0);
        ax(OP_ADD_WITH_CARRY, 5'h08, 8'h00, 8'h10, 4'h3, 8'h00);
        ax(OP_ADD, 5'h08, 8'h00, 8'h10, 4'h0, 8'h10);
    endtask
    task automatic t_sub();
        ax(OP_MOVE_IMM_TO_ACC, 5'h10, 8'h10, 8'h10, 4'h0, 8'h10);
        ax(OP_SUB, 5'h10, 8'h01, 8'h0f, 4'h2, 8'h10);
        ld(8'h10);
        ax(OP_SUB, 5'h00, 8'h00, 8'hff, 4'h4, 8'h10);
        ld(8'h7f);
        ax(OP_SUBTRACT_WITH_BORROW, 5'h00, 8'h00, 8'h7f, 4'ha,
            8'h7f);
        ax(OP_SUB, 5'h08, 8'h00, 8'h7f, 4'h7, 8'h00);
        ax(OP_SUBTRACT_WITH_BORROW, 5'h08, 8'h00, 8'h7f, 4'h6,
            8'h7f);
    endtask
    task automatic t_logic();
        ax(OP_MOVE_IMM_TO_ACC, 5'h10, 8'hf0, 8'hf0, 4'h6, 8'h7f);
        ax(OP_AND, 5'h10, 8'h0f, 8'h00, 4'h7, 8'h7f);
        ld(8'h3c);
        ax(OP_OR, 5'h00, 8'h00, 8'h3c, 4'h6, 8'h3c);
        ax(OP_XOR, 5'h08, 8'h00, 8'h3c, 4'h7, 8'h00);
        ax(OP_OR, 5'h10, 8'h81, 8'hbd, 4'h6, 8'h00);
        ax(OP_AND, 5'h00, 8'h00, 8'h00, 4'h7, 8'h00);
    endtask
    task automatic t_unary();
        ld(8'hff);
        ax(OP_INVERT, 5'h00, 8'h00, 8'h00, 4'h7, 8'hff);
        ax(OP_INCREMENT, 5'h08, 8'h00, 8'h00, 4'h7, 8'h00);
        ax(OP_DECREMENT, 5'h00, 8'h00, 8'hff, 4'h6, 8'h00);
        ax(OP_INVERT, 5'h08, 8'h00, 8'hff, 4'h6, 8'hff);
        ax(OP_DECREMENT, 5'h08, 8'h00, 8'hff, 4'h6, 8'hfe);
        ax(OP_INCREMENT, 5'h00, 8'h00, 8'hff, 4'h6, 8'hfe);
    endtask
    task automatic t_rot();
        ld(8'h81);
        ax(OP_ROTATE_RIGHT, 5'h00, 8'h00, 8'hc0, 4'h6, 8'h81);
        ax(OP_ROTATE_LEFT, 5'h08, 8'h00, 8'hc0, 4'h6, 8'h03);
        ld(8'h02);
        ax(OP_ROTATE_RIGHT_THROUGH_CARRY, 5'h00, 8'h00, 8'h81, 4'h4,
            8'h02);
        ld(8'h80);
        ax(OP_ROTATE_LEFT_THROUGH_CARRY, 5'h08, 8'h00, 8'h81, 4'h6,
            8'h00);
    endtask
    task automatic t_bits();
        ld(8'ha5);
        ax(OP_BIT_SET, 5'h09, 8'h00, 8'h81, 4'h6, 8'ha7);
        ax(OP_BIT_CLEAR, 5'h0f, 8'h00, 8'h81, 4'h6, 8'h27);
        for (int i = 0; i < 8; i++) begin
            ld(8'h00);
            ax(OP_BIT_SET, {2'b01, 3'(i)}, 8'h00, 8'h81, 4'h6,
                8'h01 << i);
        end
    endtask
    task automatic t_daa();
        ax(OP_MOVE_IMM_TO_ACC, 5'h10, 8'h00, 8'h00, 4'h6, 8'h80);
        ax(OP_ADD, 5'h10, 8'h3c, 8'h3c, 4'h0, 8'h80);
        ax(OP_DECIMAL_ADJUST, 5'h08, 8'h00, 8'h3c, 4'h0, 8'h42);
        ax(OP_ADD, 5'h10, 8'h64, 8'ha0, 4'hc, 8'h42);
        ax(OP_DECIMAL_ADJUST, 5'h08, 8'h00, 8'ha0, 4'he, 8'h06);
    endtask
    task automatic t_flow();
        fl(OP_UNCONDITIONAL_JUMP, 3'h0, 8, 3'h0);
        fl(OP_CALL, 3'h0, 8, 3'h2);
        fl(OP_SUBROUTINE_RETURN, 3'h0, 8, 3'h1);
        fl(OP_SKIP_IF_ZERO, 3'h0, 4, 3'h0);
        ld(8'h00);
        fl(OP_SKIP_IF_ZERO, 3'h0, 8, 3'h4);
        ld(8'h04);
        fl(OP_SKIP_IF_BIT_ZERO, 3'h2, 4, 3'h0);
        fl(OP_SKIP_IF_BIT_SET, 3'h2, 8, 3'h4);
        fl(OP_SKIP_IF_BIT_ZERO, 3'h3, 8, 3'h4);
        program_counter_low = 1'b1;
        ex(OP_MOVE_BYTE_TO_MEM, 5'h08, 8'h00, ea, ef, ea, 8, 3'h0);
        program_counter_low = 1'b0;
        fl(OP_NOP, 3'h0, 4, 3'h0);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        #1;
        cmp({7'h0, ready}, 8'h01);
        cmp(acc_o, 8'h00);
        cmp({4'h0, flags_o}, 8'h00);
        t_move();
        t_add();
        t_sub();
        t_logic();
        t_unary();
        t_rot();
        t_bits();
        t_daa();
        t_flow();
        final_report();
    end
endmodule
